// *** bench/serial_bus_partner.sv ***
// far-side serial node model: field bytes and line event strobes
`timescale 1ns/1ps

module serial_bus_partner (
	input  wire logic       clk_i,   // bus clock
	input  wire logic       rstn_i,  // async reset, active low
	input  wire logic       go_i,    // send one event
	input  wire logic [2:0] kind_i,  // 0 f0, 1 f1, 2 brk, 3 brk out, 4 coll, 5 edge
	input  wire logic [7:0] data_i,  // field byte to send
	output logic      [5:0] pulse_o, // one-cycle event strobes
	output logic      [7:0] byte_o   // field byte, scrambled when idle
);
	// one strobe per request; idle byte toggles so stale data never looks valid
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_o <= 6'h00;
			byte_o  <= 8'h5a;
		end else begin
			pulse_o <= go_i ? (6'h01 << kind_i) : 6'h00;
			byte_o  <= go_i ? data_i : ~byte_o;
		end
	end
endmodule // serial_bus_partner

// *** bench/testbench.sv ***
// self-checking bench for the event/compare/timer register bank
`timescale 1ns/1ps
`include "esfct_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module testbench;
	import esfct_pkg::*;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [19:0] addr_i = 20'h00000;
	logic [7:0]  wdata_i = 8'h00;
	logic        we_i = 1'b0;
	logic        re_i = 1'b0;
	logic        go = 1'b0;
	logic [2:0]  kind = 3'h0;
	logic [7:0]  data = 8'h00;
	logic [7:0]  rdata_o;
	logic [7:0]  fbyte;
	logic [5:0]  pulse;
	logic [5:0]  irq_req_o;
	logic [1:0]  timer_function_o;
	logic        timer_run_o;
	logic        timer_underflow_o;
	logic [31:0] lf = 32'h6d35a22d;
	logic [5:0]  m_flags = 6'h00;
	logic [5:0]  m_en = 6'h00;
	int          n_mismatch = 0;
	int          n_checks = 0;

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	ext_serial_flags_compare_timer i_ext_serial_flags_compare_timer (
		.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.field0_valid_i(pulse[0]), .field0_data_i(fbyte),
		.field1_valid_i(pulse[1]), .field1_data_i(fbyte),
		.break_detect_i(pulse[2]), .break_out_done_i(pulse[3]),
		.collision_i(pulse[4]), .valid_edge_i(pulse[5]), .irq_req_o(irq_req_o),
		.timer_function_o(timer_function_o), .timer_run_o(timer_run_o),
		.timer_underflow_o(timer_underflow_o));

	serial_bus_partner i_serial_bus_partner (
		.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .kind_i(kind), .data_i(data),
		.pulse_o(pulse), .byte_o(fbyte));

	// random source
	function automatic void rnd(output logic [7:0] v);
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		v = lf[7:0];
	endfunction

	// register bus cycles
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [19:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic chk_rd(input string nm, input logic [19:0] a, input logic [7:0] e);
		logic [7:0] g;
		rd(a, g);
		`CHK(nm, e, g)
	endtask

	// one event from the far side, then let flag land
	task automatic send(input logic [2:0] k, input logic [7:0] d);
		@(posedge clk_i);
		go <= 1'b1;
		kind <= k;
		data <= d;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// status and request lines against the model
	task automatic chk_ev;
		chk_rd("status", `ESF_OFF_STATUS, {2'b00, m_flags});
		#1 `CHK("irq_req", m_flags & m_en, irq_req_o)
	endtask

	task automatic clr(input logic [7:0] b);
		wr(`ESF_OFF_STATUS_CLR, b);
		m_flags = m_flags & ~b[5:0];
		chk_ev();
	endtask

	// cycles between two underflow pulses
	task automatic period(input int e);
		int n;
		n = 0;
		while (timer_underflow_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (timer_underflow_o !== 1'b1 && n < 3000);
		`CHK("underflow period", e, n)
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin : main
		static logic [19:0] ra [8] = '{`ESF_OFF_FIELD1_CTRL, `ESF_OFF_IRQ_EN, `ESF_OFF_STATUS_CLR,
			`ESF_OFF_F0_REF, `ESF_OFF_F0_MASK, `ESF_OFF_F1_PRI, `ESF_OFF_F1_SEC,
			`ESF_OFF_F1_MASK};
		static logic [7:0] rm [8] = '{8'hfc, 8'h3f, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
		logic [7:0] r, d, g, rf, mk, pr, sc;
		logic [2:0] pos;
		logic mp, ms, ex;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		// reset values of the whole map, three unmapped places too
		for (int i = 0; i < 18; i++) begin
			chk_rd("reset value", 20'h8b322 + i, (i >= 16) ? 8'hff : 8'h00);
		end
		// read/write places keep only their defined bits
		for (int i = 0; i < 8; i++) begin
			rnd(r);
			wr(ra[i], r);
			chk_rd("readback", ra[i], r & rm[i]);
			if (i == 1) m_en = r[5:0];
		end
		// read-only places ignore writes
		wr(`ESF_OFF_STATUS, 8'hff);
		wr(`ESF_OFF_F0_RX, 8'hff);
		wr(`ESF_OFF_F1_RX, 8'hff);
		chk_ev();
		chk_rd("f0 rx", `ESF_OFF_F0_RX, 8'h00);
		chk_rd("f1 rx", `ESF_OFF_F1_RX, 8'h00);
		// field0 compare under random masks
		for (int t = 0; t < 8; t++) begin
			rnd(rf);
			rnd(mk);
			rnd(d);
			if (t % 2 == 1) d = rf ^ (d & ~mk);
			wr(`ESF_OFF_F0_REF, rf);
			wr(`ESF_OFF_F0_MASK, mk);
			send(3'd0, d);
			if (((d ^ rf) & mk) == 8'h00) m_flags[1] = 1'b1;
			chk_ev();
			chk_rd("f0 rx", `ESF_OFF_F0_RX, d);
			clr(8'h02);
		end
		// field1 compare, every select code, priority bit on and off
		for (int t = 0; t < 16; t++) begin
			rnd(pr);
			rnd(sc);
			rnd(mk);
			rnd(g);
			pos = g[7:5];
			d = (t[3] ? sc : pr) ^ (g & ~mk);
			wr(`ESF_OFF_FIELD1_CTRL, {pos, t[2], t[1:0], 2'b00});
			wr(`ESF_OFF_F1_PRI, pr);
			wr(`ESF_OFF_F1_SEC, sc);
			wr(`ESF_OFF_F1_MASK, mk);
			send(3'd1, d);
			mp = ((d ^ pr) & mk) == 8'h00;
			ms = ((d ^ sc) & mk) == 8'h00;
			ex = (t[1:0] == 2'd0) ? mp : (t[1:0] == 2'd1) ? ms : (t[1:0] == 2'd2) ? (mp | ms) : 1'b0;
			if (ex) m_flags[2] = 1'b1;
			if (t[2] && d[pos]) m_flags[3] = 1'b1;
			chk_ev();
			chk_rd("f1 rx", `ESF_OFF_F1_RX, d);
			clr(8'h0c);
		end
		// line events with random enables, then all enabled, then clear one by one
		for (int k = 2; k < 6; k++) begin
			send(k[2:0], 8'h00);
			m_flags[(k < 4) ? 0 : k] = 1'b1;
			chk_ev();
			if (k == 2) clr(8'h01);
		end
		wr(`ESF_OFF_IRQ_EN, 8'hff);
		m_en = 6'h3f;
		chk_ev();
		for (int b = 0; b < 6; b++) clr(8'h01 << b);
		// function select codes
		for (int f = 0; f < 4; f++) begin
			wr(`ESF_OFF_TIMER_MODE, f[7:0]);
			#1 `CHK("function", f[1:0], timer_function_o)
		end
		// mode and control read back with reserved bits dropped
		wr(`ESF_OFF_TIMER_MODE, 8'hff);
		chk_rd("timer mode", `ESF_OFF_TIMER_MODE, 8'h7b);
		wr(`ESF_OFF_TIMER_CTRL, 8'hfe);
		chk_rd("timer control", `ESF_OFF_TIMER_CTRL, 8'h00);
		// write target: both, then reload only
		wr(`ESF_OFF_TIMER_MODE, 8'h00);
		wr(`ESF_OFF_PRESCALE, 8'h02);
		wr(`ESF_OFF_MAIN_COUNT, 8'h01);
		chk_rd("prescaler", `ESF_OFF_PRESCALE, 8'h02);
		chk_rd("main count", `ESF_OFF_MAIN_COUNT, 8'h01);
		wr(`ESF_OFF_TIMER_MODE, 8'h08);
		wr(`ESF_OFF_PRESCALE, 8'h05);
		wr(`ESF_OFF_MAIN_COUNT, 8'h03);
		chk_rd("prescaler", `ESF_OFF_PRESCALE, 8'h02);
		chk_rd("main count", `ESF_OFF_MAIN_COUNT, 8'h01);
		wr(`ESF_OFF_TIMER_MODE, 8'h00);
		wr(`ESF_OFF_PRESCALE, 8'h02);
		wr(`ESF_OFF_MAIN_COUNT, 8'h01);
		// run at two clock selects; mode changed only while stopped
		for (int c = 0; c < 2; c++) begin
			wr(`ESF_OFF_TIMER_MODE, c[0] ? 8'h20 : 8'h00);
			wr(`ESF_OFF_TIMER_CTRL, 8'h01);
			#1 `CHK("run", 1'b1, timer_run_o)
			period(c[0] ? 24 : 6);
			wr(`ESF_OFF_TIMER_CTRL, 8'h00);
			#1 `CHK("stopped", 1'b0, timer_run_o)
			rd(`ESF_OFF_PRESCALE, r);
			repeat (9) @(posedge clk_i);
			chk_rd("frozen prescaler", `ESF_OFF_PRESCALE, r);
		end
		m_flags[0] = 1'b1;
		chk_ev();
		clr(8'h01);
		// reset after a collision, timer stopped: flags and enables drop, counters return to ff
		send(3'd4, 8'h00);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		m_flags = 6'h00;
		m_en = 6'h00;
		chk_ev();
		chk_rd("reset prescaler", `ESF_OFF_PRESCALE, 8'hff);
		chk_rd("reset main count", `ESF_OFF_MAIN_COUNT, 8'hff);
		final_report();
	end

	// hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		final_report();
	end
endmodule // testbench

// *** design/ext_serial_flags_compare_timer.sv ***
// event flags, control-field compare and prescaled down-timer for the extended serial section
//
// What this block does
// - six event interrupt enables, bits zero to five
// - break flag on detect, output done, underflow
// - flags clear by write-one; clear reads zero
// - field0 match on enabled bits sets flag
// - field1 match against selected references sets flag
// - priority bit in field1 sets status bit three
// - collision report sets status bit four
// - valid receive edge sets status bit five
// - field0 reference is eight-bit read/write
// - field0 mask bit n includes position n
// - received field bytes captured, writes ignored
// - field1 primary and secondary eight-bit references
// - field1 mask enable seven sits in bit seven
// - timer run bit starts and stops counting
// - function select: timer, measure, output, prohibited
// - write target picks reload only or both
// - prescaler clock is clock divided by 2^k
// - prescaler counts down, reloads, resets to ff
// - main counter steps per prescaler underflow
// - write hits reload, read returns live count
// - reload to counter takes one clock
// - field1 select primary, secondary or both
// - priority bit position chosen by three bits
`timescale 1ns/1ps
`include "esfct_defines.svh"

module ext_serial_flags_compare_timer
	import esfct_pkg::*;
(
	input  wire logic        clk_i,               // peripheral clock, 20 MHz
	input  wire logic        rstn_i,              // async reset, active low
	input  wire logic [19:0] addr_i,              // register byte address
	input  wire logic [7:0]  wdata_i,             // write data
	input  wire logic        we_i,                // write strobe
	input  wire logic        re_i,                // read strobe
	output logic      [7:0]  rdata_o,             // read data, cycle after read
	input  wire logic        field0_valid_i,      // field0 byte received pulse
	input  wire logic [7:0]  field0_data_i,       // field0 byte
	input  wire logic        field1_valid_i,      // field1 byte received pulse
	input  wire logic [7:0]  field1_data_i,       // field1 byte
	input  wire logic        break_detect_i,      // break low width detected pulse
	input  wire logic        break_out_done_i,    // break low width output done pulse
	input  wire logic        collision_i,         // bus collision pulse
	input  wire logic        valid_edge_i,        // valid receive edge pulse
	output logic      [5:0]  irq_req_o,           // per-event interrupt requests
	output logic      [1:0]  timer_function_o,    // selected timer function
	output logic             timer_run_o,         // timer running
	output logic             timer_underflow_o    // main counter underflow pulse
);

	state_t     st_r;
	state_t     st_nxt;
	logic       tick;
	logic       pre_uf;
	logic       main_uf;
	logic       f0_hit;
	logic       f1_pri_hit;
	logic       f1_sec_hit;
	logic       f1_hit;
	logic       pri_hit;
	logic [5:0] ev_set;
	logic [5:0] ev_clr;
	logic [6:0] div_mask;
	logic       wr_pre;
	logic       wr_main;

	// prescaler count clock as a one-cycle enable from the free divider
	always_comb begin
		div_mask = 7'((8'h01 << st_r.clksel) - 8'h01);
		tick     = ((st_r.div_cnt & div_mask) == div_mask);
		pre_uf   = st_r.run && tick && (st_r.pre_cnt == 8'h00);
		main_uf  = pre_uf && (st_r.main_cnt == 8'h00);
	end

	// field compares, masked per bit position
	always_comb begin
		f0_hit     = ((field0_data_i ^ st_r.f0_ref) & st_r.f0_mask) == 8'h00;
		f1_pri_hit = ((field1_data_i ^ st_r.f1_pri) & st_r.f1_mask) == 8'h00;
		f1_sec_hit = ((field1_data_i ^ st_r.f1_sec) & st_r.f1_mask) == 8'h00;
		case (st_r.f1_sel)
			F1_SEL_PRIMARY:   f1_hit = f1_pri_hit;
			F1_SEL_SECONDARY: f1_hit = f1_sec_hit;
			F1_SEL_BOTH:      f1_hit = f1_pri_hit || f1_sec_hit;
			default:          f1_hit = 1'b0;
		endcase
		pri_hit = st_r.pri_en && field1_data_i[st_r.pri_pos];
	end

	// event set and clear vectors
	always_comb begin
		ev_set = 6'h00;
		ev_set[`ESF_EV_BREAK]      = break_detect_i || break_out_done_i || main_uf;
		ev_set[`ESF_EV_F0_MATCH]   = field0_valid_i && f0_hit;
		ev_set[`ESF_EV_F1_MATCH]   = field1_valid_i && f1_hit;
		ev_set[`ESF_EV_PRIORITY]   = field1_valid_i && pri_hit;
		ev_set[`ESF_EV_COLLISION]  = collision_i;
		ev_set[`ESF_EV_VALID_EDGE] = valid_edge_i;
		ev_clr = (we_i && addr_i == `ESF_OFF_STATUS_CLR) ? wdata_i[5:0] : 6'h00;
		wr_pre  = we_i && (addr_i == `ESF_OFF_PRESCALE);
		wr_main = we_i && (addr_i == `ESF_OFF_MAIN_COUNT);
	end

	// next state: register writes, flags, counters, read data
	always_comb begin
		st_nxt = st_r;
		st_nxt.underflow = main_uf;
		st_nxt.div_cnt   = st_r.div_cnt + 7'h01;
		// set wins over a clear in the same cycle
		st_nxt.flags = (st_r.flags & ~ev_clr) | ev_set;
		// received bytes are captured only from the receiver
		if (field0_valid_i) begin
			st_nxt.f0_rx = field0_data_i;
		end
		if (field1_valid_i) begin
			st_nxt.f1_rx = field1_data_i;
		end
		// prescaler and main counter
		if (st_r.run && tick) begin
			if (pre_uf) begin
				st_nxt.pre_cnt = st_r.pre_reload;
				if (main_uf) begin
					st_nxt.main_cnt = st_r.main_reload;
				end else begin
					st_nxt.main_cnt = st_r.main_cnt - 8'h01;
				end
			end else begin
				st_nxt.pre_cnt = st_r.pre_cnt - 8'h01;
			end
		end
		// register writes; reserved bits dropped
		if (we_i) begin
			case (addr_i)
				`ESF_OFF_IRQ_EN: begin
					st_nxt.irq_en = wdata_i[5:0];
				end
				`ESF_OFF_F0_REF: begin
					st_nxt.f0_ref = wdata_i;
				end
				`ESF_OFF_F0_MASK: begin
					st_nxt.f0_mask = wdata_i;
				end
				`ESF_OFF_F1_PRI: begin
					st_nxt.f1_pri = wdata_i;
				end
				`ESF_OFF_F1_SEC: begin
					st_nxt.f1_sec = wdata_i;
				end
				`ESF_OFF_F1_MASK: begin
					st_nxt.f1_mask = wdata_i;
				end
				`ESF_OFF_FIELD1_CTRL: begin
					st_nxt.f1_sel  = f1_sel_t'(wdata_i[`ESF_F1C_SEL_LSB +: 2]);
					st_nxt.pri_en  = wdata_i[`ESF_F1C_PRI_EN];
					st_nxt.pri_pos = wdata_i[`ESF_F1C_POS_LSB +: 3];
				end
				`ESF_OFF_TIMER_CTRL: begin
					st_nxt.run = wdata_i[`ESF_TC_RUN];
				end
				`ESF_OFF_TIMER_MODE: begin
					st_nxt.func    = timer_func_t'(wdata_i[`ESF_TM_FUNC_LSB +: 2]);
					st_nxt.wtarget = wdata_i[`ESF_TM_WTARGET];
					st_nxt.clksel  = wdata_i[`ESF_TM_CLKSEL_LSB +: 3];
				end
				`ESF_OFF_PRESCALE: begin
					st_nxt.pre_reload = wdata_i;
				end
				`ESF_OFF_MAIN_COUNT: begin
					st_nxt.main_reload = wdata_i;
				end
				default: begin
				end
			endcase
		end
		// a write with target clear also loads the live counter
		if (wr_pre && !st_r.wtarget) begin
			st_nxt.pre_cnt = wdata_i;
		end
		if (wr_main && !st_r.wtarget) begin
			st_nxt.main_cnt = wdata_i;
		end
		// read data stands for the one cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (re_i) begin
			case (addr_i)
				`ESF_OFF_IRQ_EN:      st_nxt.rdata = {2'b00, st_r.irq_en};
				`ESF_OFF_STATUS:      st_nxt.rdata = {2'b00, st_r.flags};
				`ESF_OFF_STATUS_CLR:  st_nxt.rdata = 8'h00;
				`ESF_OFF_F0_REF:      st_nxt.rdata = st_r.f0_ref;
				`ESF_OFF_F0_MASK:     st_nxt.rdata = st_r.f0_mask;
				`ESF_OFF_F0_RX:       st_nxt.rdata = st_r.f0_rx;
				`ESF_OFF_F1_PRI:      st_nxt.rdata = st_r.f1_pri;
				`ESF_OFF_F1_SEC:      st_nxt.rdata = st_r.f1_sec;
				`ESF_OFF_F1_MASK:     st_nxt.rdata = st_r.f1_mask;
				`ESF_OFF_F1_RX:       st_nxt.rdata = st_r.f1_rx;
				`ESF_OFF_FIELD1_CTRL: st_nxt.rdata = {st_r.pri_pos, st_r.pri_en,
				                                      st_r.f1_sel, 2'b00};
				`ESF_OFF_TIMER_CTRL:  st_nxt.rdata = {7'h00, st_r.run};
				`ESF_OFF_TIMER_MODE:  st_nxt.rdata = {1'b0, st_r.clksel, st_r.wtarget,
				                                      1'b0, st_r.func};
				`ESF_OFF_PRESCALE:    st_nxt.rdata = st_r.pre_cnt;
				`ESF_OFF_MAIN_COUNT:  st_nxt.rdata = st_r.main_cnt;
				default:              st_nxt.rdata = 8'h00;
			endcase
		end
		// requests follow the flags gated by their enables
		st_nxt.irq_req = st_nxt.flags & st_nxt.irq_en;
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r             <= '0;
			st_r.f1_sel      <= F1_SEL_PRIMARY;
			st_r.func        <= TF_TIMER;
			st_r.f0_ref      <= `ESF_RST_ZERO;
			st_r.pre_reload  <= `ESF_RST_COUNTER;
			st_r.pre_cnt     <= `ESF_RST_COUNTER;
			st_r.main_reload <= `ESF_RST_COUNTER;
			st_r.main_cnt    <= `ESF_RST_COUNTER;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign rdata_o           = st_r.rdata;
	assign irq_req_o         = st_r.irq_req;
	assign timer_function_o  = st_r.func;
	assign timer_run_o       = st_r.run;
	assign timer_underflow_o = st_r.underflow;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_collision_set_wins;
		collision_i |=> st_r.flags[`ESF_EV_COLLISION];
	endproperty
	a_collision_set_wins: assert property (p_collision_set_wins)
		else $error("collision flag not set");

	property p_clear_f0;
		we_i && addr_i == `ESF_OFF_STATUS_CLR && wdata_i[1] && !field0_valid_i
			|=> !st_r.flags[`ESF_EV_F0_MATCH];
	endproperty
	a_clear_f0: assert property (p_clear_f0)
		else $error("field0 flag not cleared");

	property p_clear_reads_zero;
		re_i && addr_i == `ESF_OFF_STATUS_CLR |=> rdata_o == 8'h00;
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero)
		else $error("clear register read nonzero");

	property p_f0_match;
		field0_valid_i && (((field0_data_i ^ st_r.f0_ref) & st_r.f0_mask) == 8'h00)
			|=> st_r.flags[`ESF_EV_F0_MATCH] ##1 irq_req_o[1] == st_r.irq_en[1] || !st_r.flags[1];
	endproperty
	a_f0_match: assert property (p_f0_match)
		else $error("field0 match missed");

	property p_f1_capture;
		field1_valid_i |=> st_r.f1_rx == $past(field1_data_i);
	endproperty
	a_f1_capture: assert property (p_f1_capture)
		else $error("field1 byte not captured");

	property p_irq_gate;
		irq_req_o == (st_r.flags & st_r.irq_en);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("request not flag and enable");

	property p_pre_reload;
		pre_uf && !wr_pre |=> st_r.pre_cnt == $past(st_r.pre_reload);
	endproperty
	a_pre_reload: assert property (p_pre_reload)
		else $error("prescaler reload not in one cycle");

	property p_stopped;
		!st_r.run && !we_i |=> $stable(st_r.pre_cnt) && $stable(st_r.main_cnt);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("counter moved while stopped");

	property p_underflow_break;
		main_uf |=> st_r.flags[`ESF_EV_BREAK] && timer_underflow_o;
	endproperty
	a_underflow_break: assert property (p_underflow_break)
		else $error("underflow did not set break flag");

	property p_write_both;
		wr_pre && !st_r.wtarget
			|=> st_r.pre_cnt == $past(wdata_i) && st_r.pre_reload == $past(wdata_i);
	endproperty
	a_write_both: assert property (p_write_both)
		else $error("write did not load counter");

	property p_break_set;
		break_detect_i || break_out_done_i |=> st_r.flags[`ESF_EV_BREAK];
	endproperty
	a_break_set: assert property (p_break_set)
		else $error("break flag not set");

	property p_priority_set;
		field1_valid_i && st_r.pri_en && field1_data_i[st_r.pri_pos]
			|=> st_r.flags[`ESF_EV_PRIORITY];
	endproperty
	a_priority_set: assert property (p_priority_set)
		else $error("priority flag not set");

	property p_valid_edge_set;
		valid_edge_i |=> st_r.flags[`ESF_EV_VALID_EDGE];
	endproperty
	a_valid_edge_set: assert property (p_valid_edge_set)
		else $error("valid edge flag not set");

	property p_flags_hold;
		!(we_i && addr_i == `ESF_OFF_STATUS_CLR)
			|=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold)
		else $error("flag fell without a clear write");

	property p_f0_rx_hold;
		!field0_valid_i |=> $stable(st_r.f0_rx);
	endproperty
	a_f0_rx_hold: assert property (p_f0_rx_hold)
		else $error("field0 byte changed without reception");

	property p_main_reload;
		main_uf && !wr_main |=> st_r.main_cnt == $past(st_r.main_reload);
	endproperty
	a_main_reload: assert property (p_main_reload)
		else $error("main counter reload not in one cycle");

	property p_enable_reserved;
		re_i && addr_i == `ESF_OFF_IRQ_EN |=> rdata_o[7:6] == 2'b00;
	endproperty
	a_enable_reserved: assert property (p_enable_reserved)
		else $error("reserved enable bits read nonzero");

	property p_rdata_idle;
		!re_i |=> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");

endmodule // ext_serial_flags_compare_timer

// *** inc/esfct_defines.svh ***
// register offsets, field positions, reset values and timing for the event/compare/timer bank
`ifndef ESFCT_DEFINES_SVH
`define ESFCT_DEFINES_SVH

// register byte addresses
`define ESF_OFF_FIELD1_CTRL   20'h8b322
`define ESF_OFF_IRQ_EN        20'h8b326
`define ESF_OFF_STATUS        20'h8b327
`define ESF_OFF_STATUS_CLR    20'h8b328
`define ESF_OFF_F0_REF        20'h8b329
`define ESF_OFF_F0_MASK       20'h8b32a
`define ESF_OFF_F0_RX         20'h8b32b
`define ESF_OFF_F1_PRI        20'h8b32c
`define ESF_OFF_F1_SEC        20'h8b32d
`define ESF_OFF_F1_MASK       20'h8b32e
`define ESF_OFF_F1_RX         20'h8b32f
`define ESF_OFF_TIMER_CTRL    20'h8b330
`define ESF_OFF_TIMER_MODE    20'h8b331
`define ESF_OFF_PRESCALE      20'h8b332
`define ESF_OFF_MAIN_COUNT    20'h8b333

// event bit positions, shared by enable, status and clear
`define ESF_EV_BREAK          0
`define ESF_EV_F0_MATCH       1
`define ESF_EV_F1_MATCH       2
`define ESF_EV_PRIORITY       3
`define ESF_EV_COLLISION      4
`define ESF_EV_VALID_EDGE     5
`define ESF_EV_MASK           8'h3f

// field1 control layout
`define ESF_F1C_SEL_LSB       2
`define ESF_F1C_PRI_EN        4
`define ESF_F1C_POS_LSB       5

// timer control and mode layout
`define ESF_TC_RUN            0
`define ESF_TM_FUNC_LSB       0
`define ESF_TM_WTARGET        3
`define ESF_TM_CLKSEL_LSB     4

// reset values
`define ESF_RST_ZERO          8'h00
`define ESF_RST_COUNTER       8'hff

// reload transfer takes this many clock cycles
`define ESF_RELOAD_CYCLES     1

`endif

// *** inc/esfct_pkg.sv ***
// types for the event/compare/timer bank
package esfct_pkg;

	typedef enum logic [1:0] {
		TF_TIMER         = 2'b00,
		TF_BREAK_MEASURE = 2'b01,
		TF_BREAK_OUTPUT  = 2'b10,
		TF_PROHIBITED    = 2'b11
	} timer_func_t;

	typedef enum logic [1:0] {
		F1_SEL_PRIMARY   = 2'b00,
		F1_SEL_SECONDARY = 2'b01,
		F1_SEL_BOTH      = 2'b10,
		F1_SEL_BAD       = 2'b11
	} f1_sel_t;

	typedef struct packed {
		logic [5:0]  irq_en;
		logic [5:0]  flags;
		logic [7:0]  f0_ref;
		logic [7:0]  f0_mask;
		logic [7:0]  f0_rx;
		logic [7:0]  f1_pri;
		logic [7:0]  f1_sec;
		logic [7:0]  f1_mask;
		logic [7:0]  f1_rx;
		f1_sel_t     f1_sel;
		logic        pri_en;
		logic [2:0]  pri_pos;
		logic        run;
		timer_func_t func;
		logic        wtarget;
		logic [2:0]  clksel;
		logic [6:0]  div_cnt;
		logic [7:0]  pre_reload;
		logic [7:0]  pre_cnt;
		logic [7:0]  main_reload;
		logic [7:0]  main_cnt;
		logic [7:0]  rdata;
		logic [5:0]  irq_req;
		logic        underflow;
	} state_t;

endpackage
